// ===== rtl/rx_mode_pkg.sv
// Functional notes
// [R1] Bit 7 set: check the one-byte checksum after each line; clear: no check.
// [R2] Each failed line checksum is recorded in the protection status register.
// [R3] Bit 6 picks back-channel rate: 0 divide-by-4, 1 divide-by-2.
// [R4] Divider select is ignored while the fast back-channel bit is 1.
// [R5] Rate changes cause brief back-channel errors; integrity logic tolerates them.
// [R6] Remote side sets auto-acknowledge before changing the rate remotely.
// [R7] Bit 5 set (reset 1): audio mode follows received auxiliary codes.
// [R8] Bit 4 set runs the back channel at fixed 20 Mbps, overriding the divider.
// [R9] Power-up value of the fast bit comes from the strap pin.
// [R10] Bit 3 picks cable: 0 shielded twisted pair, 1 coax.
// [R11] Cable bit resets from the strap pin and stays writable.
// [R12] Bit 2 is read-only relay strap indication; writes are ignored.
// [R13] Bits 1 and 0 read zero and writes to them change nothing.
`default_nettype none
package rx_mode_pkg;
  // Timing
  localparam int CLK_MHZ        = 100;
  localparam int FAST_RATE_MBPS = 20;
  localparam int FAST_DIV       = CLK_MHZ / FAST_RATE_MBPS;
  localparam int DIV4_COUNT     = 4;
  localparam int DIV2_COUNT     = 2;
  localparam int SETTLE_NS      = 1000;
  localparam int SETTLE_CYCLES  = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_MODE   = 6'h23;
  localparam logic [5:0] IDX_IRQST  = 6'h38;
  localparam logic [5:0] IDX_IRQMSK = 6'h39;
  localparam logic [5:0] IDX_BCST   = 6'h3A;
  localparam logic [5:0] IDX_CPST   = 6'h3B;
  // Mode register fields
  localparam int BIT_CSUM  = 7;
  localparam int BIT_DIVSL = 6;
  localparam int BIT_AUTO  = 5;
  localparam int BIT_FAST  = 4;
  localparam int BIT_COAX  = 3;
  localparam int BIT_RELAY = 2;
  localparam logic RST_CSUM  = 1'b0;
  localparam logic RST_DIVSL = 1'b0;
  localparam logic RST_AUTO  = 1'b1;
  // Strap code bits
  localparam int STRAP_W     = 3;
  localparam int STRAP_FAST  = 2;
  localparam int STRAP_COAX  = 1;
  localparam int STRAP_RELAY = 0;
  // Interrupt bits
  localparam int IRQ_W     = 3;
  localparam int IRQ_CSUM  = 0;
  localparam int IRQ_RATE  = 1;
  localparam int IRQ_AUDIO = 2;
  // Status field positions
  localparam int BCST_RATE   = 8;
  localparam int BCST_SETTLE = 10;
  localparam int CPST_CNT    = 8;

  typedef enum logic [1:0] {RATE_DIV4, RATE_DIV2, RATE_FAST} rate_t;

  function automatic logic [7:0] addr_of(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction : addr_of
endpackage : rx_mode_pkg
`default_nettype wire

// ===== rtl/line_check_if.sv
`default_nettype none
// Carries line bytes to the checker and its verdicts back
interface line_check_if;
  logic       enable;
  logic       byteValid;
  logic [7:0] byteData;
  logic       isChecksum;
  logic       failPulse;
  logic       passPulse;
  modport ctl (output enable, byteValid, byteData, isChecksum,
               input  failPulse, passPulse);
  modport chk (input  enable, byteValid, byteData, isChecksum,
               output failPulse, passPulse);
endinterface : line_check_if
`default_nettype wire

// ===== rtl/line_checksum_checker.sv
`default_nettype none
module line_checksum_checker (
  input wire logic  core_clk,
  input wire logic  rst,
  line_check_if.chk lc
);
  logic [7:0] sum_r;
  logic       fail_r;
  logic       pass_r;

  ////////////////////////////////////////////////////////////
  // Running sum; cleared at each checksum byte and while off
  always_ff @(posedge core_clk) begin
    if (rst || !lc.enable) begin
      sum_r <= 8'h00;
    end else if (lc.byteValid) begin
      sum_r <= lc.isChecksum ? 8'h00 : 8'(sum_r + lc.byteData);
    end
  end

  // Compare only when enabled; a disabled checker never flags
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fail_r <= 1'b0;
      pass_r <= 1'b0;
    end else begin
      fail_r <= lc.enable && lc.byteValid && lc.isChecksum
                && (lc.byteData != sum_r);                 // see [R1]
      pass_r <= lc.enable && lc.byteValid && lc.isChecksum
                && (lc.byteData == sum_r);
    end
  end

  assign lc.failPulse = fail_r;
  assign lc.passPulse = pass_r;

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_csum_off;
    !lc.enable |=> !lc.failPulse && !lc.passPulse;
  endproperty
  a_csum_off: assert property (p_csum_off) // see [R1]
    else $error("checker flagged while disabled");

  property p_csum_bad;
    lc.enable && lc.byteValid && lc.isChecksum && lc.byteData != sum_r
      |=> lc.failPulse;
  endproperty
  a_csum_bad: assert property (p_csum_bad) // see [R1]
    else $error("bad checksum not flagged");
endmodule : line_checksum_checker
`default_nettype wire

// ===== rtl/rx_mode_status_control.sv
`default_nettype none
module rx_mode_status_control
  import rx_mode_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_CYCLES,
  parameter int AUX_W      = 4
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic [7:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  input  wire logic [3:0]         byteenable,
  output logic [31:0]             readdata,
  output logic                    waitrequest,
  input  wire logic [STRAP_W-1:0] configStrapPinOne,
  input  wire logic               lineByteValid,
  input  wire logic [7:0]         lineByte,
  input  wire logic               lineByteIsChecksum,
  input  wire logic               oscTick,
  input  wire logic               backErrIn,
  input  wire logic               auxCodeValid,
  input  wire logic [AUX_W-1:0]   auxCode,
  output rate_t                   backRate,
  output logic                    backTick,
  output logic                    backSettling,
  output logic                    cableCoax,
  output logic                    relayMode,
  output logic [1:0]              audioMode,
  output logic                    irq
);
  // Effective back-channel rate; fast mode wins over the divider bit
  function automatic rate_t rate_of(input logic fast, input logic divSel);
    if (fast) begin
      return RATE_FAST;
    end else if (divSel) begin
      return RATE_DIV2;
    end
    return RATE_DIV4;
  endfunction : rate_of

  // Divider terminal count for each rate
  function automatic logic [2:0] limit_of(input rate_t r);
    unique case (r)
      RATE_FAST: return 3'(FAST_DIV);
      RATE_DIV2: return 3'(DIV2_COUNT);
      default:   return 3'(DIV4_COUNT);
    endcase
  endfunction : limit_of

  // Serial audio mode from the low code bits
  function automatic logic [1:0] aux_to_mode(input logic [AUX_W-1:0] c);
    return c[1:0];
  endfunction : aux_to_mode

  logic             csumEn_r;
  logic             divSel_r;
  logic             auto_r;
  logic             fast_r;
  logic             coax_r;
  logic             relay_r;
  logic             strapPending_r;
  logic             ack_r;
  logic [31:0]      rdData_r;
  logic [31:0]      rdNxt;
  logic             wrMode;
  logic             wrIrqSt;
  logic             wrIrqMsk;
  logic             wrCpSt;
  logic [IRQ_W-1:0] irqSt_r;
  logic [IRQ_W-1:0] irqMsk_r;
  logic [IRQ_W-1:0] irqEv;
  rate_t            rateEff_r;
  rate_t            rateNxt;
  logic             rateChg;
  logic [2:0]       divCnt_r;
  logic             divStep;
  logic             tick_r;
  logic [15:0]      settleCnt_r;
  logic [7:0]       bcErrCnt_r;
  logic [1:0]       audio_r;
  logic             audioChg;
  logic             cpFail_r;
  logic [7:0]       cpCnt_r;
  line_check_if     lc ();

  ////////////////////////////////////////////////////////////
  // Bus slave: one wait state so read data come from a flop
  assign waitrequest = (read || write) && !ack_r;
  assign readdata    = rdData_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (read || write) && !ack_r;
    end
  end

  // Writes land only on the edge that ends the wait
  assign wrMode   = write && ack_r && byteenable[0] && address == addr_of(IDX_MODE);
  assign wrIrqSt  = write && ack_r && byteenable[0] && address == addr_of(IDX_IRQST);
  assign wrIrqMsk = write && ack_r && byteenable[0] && address == addr_of(IDX_IRQMSK);
  assign wrCpSt   = write && ack_r && byteenable[0] && address == addr_of(IDX_CPST);

  // Read decode; unmapped addresses read zero
  always_comb begin
    rdNxt = 32'h0000_0000;
    unique case (address)
      addr_of(IDX_MODE): begin
        rdNxt[BIT_CSUM]  = csumEn_r;
        rdNxt[BIT_DIVSL] = divSel_r;
        rdNxt[BIT_AUTO]  = auto_r;
        rdNxt[BIT_FAST]  = fast_r;
        rdNxt[BIT_COAX]  = coax_r;
        rdNxt[BIT_RELAY] = relay_r;                 // Low two bits stay zero, see [R13]
      end
      addr_of(IDX_IRQST):  rdNxt[IRQ_W-1:0] = irqSt_r;
      addr_of(IDX_IRQMSK): rdNxt[IRQ_W-1:0] = irqMsk_r;
      addr_of(IDX_BCST): begin
        rdNxt[7:0]                  = bcErrCnt_r;
        rdNxt[BCST_RATE+1:BCST_RATE] = rateEff_r;
        rdNxt[BCST_SETTLE]          = backSettling;
      end
      addr_of(IDX_CPST): begin
        rdNxt[0]                  = cpFail_r;
        rdNxt[CPST_CNT+7:CPST_CNT] = cpCnt_r;
      end
      default: rdNxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdData_r <= 32'h0000_0000;
    end else if (read && !ack_r) begin
      rdData_r <= rdNxt;
    end
  end

  ////////////////////////////////////////////////////////////
  // Strap capture one edge after reset release
  always_ff @(posedge core_clk) begin
    if (rst) begin
      strapPending_r <= 1'b1;
    end else begin
      strapPending_r <= 1'b0;
    end
  end

  // Relay flag: loaded from the strap only, no software path
  always_ff @(posedge core_clk) begin
    if (rst) begin
      relay_r <= 1'b0;
    end else if (strapPending_r) begin
      relay_r <= configStrapPinOne[STRAP_RELAY];    // see [R12]
    end
  end

  // Strapped fields; the strap load beats a write in that cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fast_r <= 1'b0;
      coax_r <= 1'b0;
    end else if (strapPending_r) begin
      fast_r <= configStrapPinOne[STRAP_FAST];      // see [R9]
      coax_r <= configStrapPinOne[STRAP_COAX];      // see [R11]
    end else if (wrMode) begin
      fast_r <= writedata[BIT_FAST];                // see [R8]
      coax_r <= writedata[BIT_COAX];                // see [R10]
    end
  end

  // Plain software fields; reserved bits are dropped, see [R13]
  always_ff @(posedge core_clk) begin
    if (rst) begin
      csumEn_r <= RST_CSUM;
      divSel_r <= RST_DIVSL;
      auto_r   <= RST_AUTO;
    end else if (wrMode) begin
      csumEn_r <= writedata[BIT_CSUM];              // see [R1]
      divSel_r <= writedata[BIT_DIVSL];             // see [R3]
      auto_r   <= writedata[BIT_AUTO];              // see [R7]
    end
  end

  assign cableCoax = coax_r;                        // see [R10]
  assign relayMode = relay_r;

  ////////////////////////////////////////////////////////////
  // Back-channel rate; divider bit is masked by fast mode
  assign rateNxt = rate_of(fast_r, divSel_r);        // see [R4]
  assign rateChg = rateNxt != rateEff_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rateEff_r <= RATE_DIV4;
    end else begin
      rateEff_r <= rateNxt;                         // see [R3]
    end
  end

  assign backRate = rateEff_r;

  // Fast mode counts core cycles; divider modes count oscillator ticks
  assign divStep = (rateEff_r == RATE_FAST) || oscTick;   // see [R8]

  always_ff @(posedge core_clk) begin
    if (rst || rateChg) begin
      divCnt_r <= 3'd0;
      tick_r   <= 1'b0;
    end else begin
      tick_r <= divStep && (divCnt_r == 3'(limit_of(rateEff_r) - 3'd1));
      if (divStep) begin
        divCnt_r <= (divCnt_r == 3'(limit_of(rateEff_r) - 3'd1))
                    ? 3'd0 : 3'(divCnt_r + 3'd1);
      end
    end
  end

  assign backTick = tick_r;

  // Blanking window after a rate change; errors then are expected
  always_ff @(posedge core_clk) begin
    if (rst) begin
      settleCnt_r <= 16'h0000;
    end else if (rateChg) begin
      settleCnt_r <= 16'(SETTLE_CYC);              // see [R5]
    end else if (settleCnt_r != 16'h0000) begin
      settleCnt_r <= 16'(settleCnt_r - 16'h0001);
    end
  end

  assign backSettling = settleCnt_r != 16'h0000;

  // Integrity count saturates so a flood cannot wrap to zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bcErrCnt_r <= 8'h00;
    end else if (backErrIn && !backSettling && !rateChg && bcErrCnt_r != 8'hFF) begin
      bcErrCnt_r <= 8'(bcErrCnt_r + 8'h01);        // see [R5]
    end
  end

  ////////////////////////////////////////////////////////////
  // Audio format follows aux codes only while auto detect is on
  assign audioChg = auto_r && auxCodeValid && aux_to_mode(auxCode) != audio_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      audio_r <= 2'b00;
    end else if (auto_r && auxCodeValid) begin
      audio_r <= aux_to_mode(auxCode);              // see [R7]
    end
  end

  assign audioMode = audio_r;

  ////////////////////////////////////////////////////////////
  // Line checksum checker
  assign lc.enable     = csumEn_r;                  // see [R1]
  assign lc.byteValid  = lineByteValid;
  assign lc.byteData   = lineByte;
  assign lc.isChecksum = lineByteIsChecksum;

  line_checksum_checker u_check (
    .core_clk (core_clk),
    .rst      (rst),
    .lc       (lc)
  );

  // Protection status: sticky fail flag, set beats write-one clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cpFail_r <= 1'b0;
    end else if (lc.failPulse) begin
      cpFail_r <= 1'b1;                             // see [R2]
    end else if (wrCpSt && writedata[0]) begin
      cpFail_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cpCnt_r <= 8'h00;
    end else if (lc.failPulse && cpCnt_r != 8'hFF) begin
      cpCnt_r <= 8'(cpCnt_r + 8'h01);              // see [R2]
    end
  end

  ////////////////////////////////////////////////////////////
  // Interrupts: sticky events, write one to clear, set wins
  assign irqEv[IRQ_CSUM]  = lc.failPulse;
  assign irqEv[IRQ_RATE]  = rateChg;
  assign irqEv[IRQ_AUDIO] = audioChg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqSt_r <= '0;
    end else begin
      irqSt_r <= irqEv | (irqSt_r & ~({IRQ_W{wrIrqSt}} & writedata[IRQ_W-1:0]));
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqMsk_r <= '0;
    end else if (wrIrqMsk) begin
      irqMsk_r <= writedata[IRQ_W-1:0];
    end
  end

  assign irq = |(irqSt_r & irqMsk_r);

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_fail_rec;
    lc.failPulse |=> cpFail_r && irqSt_r[IRQ_CSUM];
  endproperty
  a_fail_rec: assert property (p_fail_rec) // see [R2]
    else $error("checksum failure not recorded");

  property p_rate_sel;
    1'b1 |=> rateEff_r == rate_of($past(fast_r), $past(divSel_r));
  endproperty
  a_rate_sel: assert property (p_rate_sel) // see [R3]
    else $error("rate does not follow settings");

  property p_fast_wins;
    fast_r && $past(fast_r) && $changed(divSel_r) |-> rateEff_r == RATE_FAST;
  endproperty
  a_fast_wins: assert property (p_fast_wins) // see [R4]
    else $error("divider select acted in fast mode");

  property p_settle;
    rateChg |=> backSettling && $stable(bcErrCnt_r);
  endproperty
  a_settle: assert property (p_settle) // see [R5]
    else $error("rate change not blanked");

  property p_fast_tick;
    backTick && rateEff_r == RATE_FAST && !rateChg ##1 !rateChg[*5]
      |-> backTick && !$past(backTick);
  endproperty
  a_fast_tick: assert property (p_fast_tick) // see [R8]
    else $error("fast tick spacing wrong");

  property p_audio;
    auto_r && auxCodeValid |=> audio_r == aux_to_mode($past(auxCode));
  endproperty
  a_audio: assert property (p_audio) // see [R7]
    else $error("audio mode not taken from aux code");

  property p_strap;
    strapPending_r |=> fast_r == $past(configStrapPinOne[STRAP_FAST])
      && coax_r == $past(configStrapPinOne[STRAP_COAX]);
  endproperty
  a_strap: assert property (p_strap) // see [R9]
    else $error("strapped fields not loaded");

  property p_relay_ro;
    !strapPending_r |=> $stable(relay_r);
  endproperty
  a_relay_ro: assert property (p_relay_ro) // see [R12]
    else $error("relay flag changed after strap");

  property p_rsvd;
    read && ack_r && address == addr_of(IDX_MODE) |-> readdata[1:0] == 2'b00;
  endproperty
  a_rsvd: assert property (p_rsvd) // see [R13]
    else $error("reserved bits read nonzero");
endmodule : rx_mode_status_control
`default_nettype wire

// ===== bench/remote_serializer_model.sv
`default_nettype none
// Far-side serializer: line bytes, oscillator tick, back-channel errors, aux codes
module remote_serializer_model (
  input  wire logic  core_clk,
  output logic       lineByteValid,
  output logic [7:0] lineByte,
  output logic       lineByteIsChecksum,
  output logic       oscTick,
  output logic       backErrIn,
  output logic       auxCodeValid,
  output logic [3:0] auxCode
);
  timeunit 1ns;
  timeprecision 1ns;

  logic autoAck_r;  // Raised by prep_rate before the t_rate writes; drives no design input

  ////////////////////////////////////////////////////////////////////////////////
  // Idle values at time zero
  initial begin
    lineByteValid = 1'b0;
    lineByte = 8'hA5;
    lineByteIsChecksum = 1'b0;
    oscTick = 1'b0;
    backErrIn = 1'b0;
    auxCodeValid = 1'b0;
    auxCode = 4'h9;
    autoAck_r = 1'b0;
  end

  // Divider tick every other cycle; runs free like a real oscillator
  always @(posedge core_clk) oscTick <= ~oscTick;

  ////////////////////////////////////////////////////////////////////////////////
  // One byte per edge; caller enters just after a rising edge
  task automatic put(input logic [7:0] v, input logic c);
    lineByteValid <= 1'b1;
    lineByte <= v;
    lineByteIsChecksum <= c;
    @(posedge core_clk);
  endtask : put

  // Two data bytes then the checksum; bad adds one so the sum misses
  task automatic send_line(input logic [7:0] a, input logic [7:0] b, input logic bad);
    logic [7:0] s;
    s = a + b + {7'h0, bad};
    put(a, 1'b0);
    put(b, 1'b0);
    put(s, 1'b1);
    lineByteValid <= 1'b0;
    lineByte <= ~s;  // Released bus shows no stale byte
    lineByteIsChecksum <= 1'b0;
  endtask : send_line

  task automatic send_aux(input logic [3:0] c);
    auxCodeValid <= 1'b1;
    auxCode <= c;
    @(posedge core_clk);
    auxCodeValid <= 1'b0;
    auxCode <= ~c;
  endtask : send_aux

  // Error held for n edges; one call per burst so the strobe is never re-driven in one step
  task automatic pulse_err(input int n);
    backErrIn <= 1'b1;
    repeat (n) @(posedge core_clk);
    backErrIn <= 1'b0;
  endtask : pulse_err

  // Model-only flag, no design input follows it
  task automatic prep_rate();
    autoAck_r = 1'b1;
  endtask : prep_rate
endmodule : remote_serializer_model
`default_nettype wire

// ===== bench/testbench.sv
`default_nettype none
module testbench;
  import rx_mode_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [7:0] MODE = 8'h8C;
  localparam logic [7:0] IST  = 8'hE0;
  localparam logic [7:0] IMSK = 8'hE4;
  localparam logic [7:0] BCST = 8'hE8;
  localparam logic [7:0] CPST = 8'hEC;

  logic        core_clk;
  logic        rst;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [2:0]  configStrapPinOne;
  logic        lineByteValid;
  logic [7:0]  lineByte;
  logic        lineByteIsChecksum;
  logic        oscTick;
  logic        backErrIn;
  logic        auxCodeValid;
  logic [3:0]  auxCode;
  rate_t       backRate;
  logic        backTick;
  logic        backSettling;
  logic        cableCoax;
  logic        relayMode;
  logic [1:0]  audioMode;
  logic        irq;
  logic [31:0] rdq;
  int          fail_count;
  int          num_checks;

  rx_mode_status_control #(.SETTLE_CYC(4), .AUX_W(4)) u_rx_mode_status_control (
    .core_clk(core_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .configStrapPinOne(configStrapPinOne),
    .lineByteValid(lineByteValid), .lineByte(lineByte),
    .lineByteIsChecksum(lineByteIsChecksum), .oscTick(oscTick), .backErrIn(backErrIn),
    .auxCodeValid(auxCodeValid), .auxCode(auxCode), .backRate(backRate),
    .backTick(backTick), .backSettling(backSettling), .cableCoax(cableCoax),
    .relayMode(relayMode), .audioMode(audioMode), .irq(irq));

  remote_serializer_model u_ser (
    .core_clk(core_clk), .lineByteValid(lineByteValid), .lineByte(lineByte),
    .lineByteIsChecksum(lineByteIsChecksum), .oscTick(oscTick), .backErrIn(backErrIn),
    .auxCodeValid(auxCodeValid), .auxCode(auxCode));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; the run needs a few hundred cycles at most
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #200_000;
    fail_count++;
    test_done();
  end

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon access: held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    address <= a;
    writedata <= {24'h00_0000, d};
    read <= !w;
    write <= w;
    while (!done) begin
      @(posedge core_clk);
      done = (waitrequest === 1'b0);  // Seen before this edge's updates land
      n++;
    end
    rdq = readdata;  // Taken at the completing edge, where it stands
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);  // Idle edge so the next call never re-drives in this step
    check("busWait", 32'(n), 32'h2);  // One wait state, then completion
  endtask : bus

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    check(name, rdq, exp);
  endtask : rchk

  task automatic do_reset(input logic [2:0] s);
    configStrapPinOne <= s;
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);  // Strap load and any rate change land first
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////////
  // Strap-loaded fields, read-only relay bit, reserved bits, unmapped address
  task automatic t_strap();
    rchk("modeStrap", MODE, 32'h0000_003C);
    check("coaxStrap", {31'h0, cableCoax}, 32'h1);
    check("relayStrap", {31'h0, relayMode}, 32'h1);
    bus(1'b1, MODE, 8'hFF);
    rchk("modeAll", MODE, 32'h0000_00FC);
    bus(1'b1, MODE, 8'h03);
    rchk("modeLow", MODE, 32'h0000_0004);
    check("coaxOff", {31'h0, cableCoax}, 32'h0);
    // Lane 0 off: the write is acknowledged but must not land
    byteenable <= 4'h0;
    bus(1'b1, MODE, 8'hFF);
    byteenable <= 4'hF;
    rchk("modeNoLane", MODE, 32'h0000_0004);
    rchk("unmapped", 8'h00, 32'h0000_0000);
  endtask : t_strap

  // Each rate setting: enum and tick period over 40 cycles
  task automatic t_rate();
    logic [7:0] m[4] = '{8'h20, 8'h60, 8'h30, 8'h70};
    rate_t r[4] = '{RATE_DIV4, RATE_DIV2, RATE_FAST, RATE_FAST};
    int per[4] = '{8, 4, 5, 5};
    int n;
    u_ser.prep_rate();
    check("autoAck", {31'h0, u_ser.autoAck_r}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, MODE, m[i]);
      repeat (12) @(posedge core_clk);
      check("backRate", 32'(backRate), 32'(r[i]));
      n = 0;
      repeat (40) begin
        @(posedge core_clk);
        if (backTick === 1'b1) n++;
      end
      check("tickCount", 32'(n), 32'(40 / per[i]));
    end
  endtask : t_rate

  // Errors during the settling window are not counted; later ones are
  task automatic t_settle();
    int n;
    n = 0;
    bus(1'b1, MODE, 8'h20);
    while (backSettling !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      n++;
    end
    check("settleRise", {31'h0, backSettling}, 32'h1);
    u_ser.pulse_err(1);
    repeat (8) @(posedge core_clk);
    u_ser.pulse_err(3);
    @(posedge core_clk);
    rchk("errCount", BCST, 32'h0000_0003);
  endtask : t_settle

  // Checksum off, good, bad, clear, then masked
  task automatic t_csum();
    bus(1'b1, IMSK, 8'h01);
    u_ser.send_line(8'h10, 8'h20, 1'b1);
    repeat (4) @(posedge core_clk);
    rchk("csumOff", CPST, 32'h0000_0000);
    bus(1'b1, MODE, 8'hA0);
    u_ser.send_line(8'hF0, 8'h20, 1'b0);
    repeat (4) @(posedge core_clk);
    rchk("csumGood", CPST, 32'h0000_0000);
    u_ser.send_line(8'h10, 8'h20, 1'b1);
    repeat (4) @(posedge core_clk);
    rchk("csumBad", CPST, 32'h0000_0101);
    check("irqCsum", {31'h0, irq}, 32'h1);
    bus(1'b1, IST, 8'h01);
    bus(1'b1, CPST, 8'h01);
    check("irqClear", {31'h0, irq}, 32'h0);
    rchk("csumClr", CPST, 32'h0000_0100);
    bus(1'b1, IMSK, 8'h00);
    u_ser.send_line(8'h01, 8'h02, 1'b1);
    repeat (4) @(posedge core_clk);
    check("irqMasked", {31'h0, irq}, 32'h0);
    bus(1'b0, IST, 8'h00);
    check("istSticky", rdq & 32'h1, 32'h1);
  endtask : t_csum

  // Aux codes steer audio mode only while auto detect is on
  task automatic t_audio();
    bus(1'b1, IMSK, 8'h04);
    u_ser.send_aux(4'h6);
    repeat (2) @(posedge core_clk);
    check("audioAuto", {30'h0, audioMode}, 32'h2);
    check("irqAudio", {31'h0, irq}, 32'h1);
    bus(1'b1, IST, 8'h04);
    bus(1'b1, MODE, 8'h80);
    u_ser.send_aux(4'h1);
    repeat (2) @(posedge core_clk);
    check("audioHeld", {30'h0, audioMode}, 32'h2);
    check("irqQuiet", {31'h0, irq}, 32'h0);
  endtask : t_audio

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    fail_count = 0;
    num_checks = 0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'hF;
    do_reset(3'b111);
    t_strap();
    do_reset(3'b000);
    rchk("modeReset", MODE, 32'h0000_0020);
    t_rate();
    t_settle();
    t_csum();
    t_audio();
    test_done();
  end
endmodule : testbench
`default_nettype wire
